// >>> verilog/ssup_ctrl.sv
// Power source selection, USB power role and current limit control
//
// What this block does
// R01 - Wall supply chosen whenever its voltage sits in the 4.0V-5.5V window.
// R02 - Wall still chosen below 4.0V when it is the highest source.
// R03 - USB never chosen while a suitable wall supply is present.
// R04 - Wall becoming unsuitable with USB available switches source to USB.
// R05 - Battery chosen when it exceeds both wall and USB supplies.
// R06 - On wall with cell: trickle in OFF, HIBERNATE, ACTIVE; fast in ACTIVE.
// R07 - Sink role by default; role bit 13 set makes the device a source.
// R08 - Sink role takes USB when wall is out of limits and USB highest.
// R09 - OFF to ACTIVE under USB power only with USB at least 4.0V.
// R10 - Role high-power bit sets 100mA/500mA; a write takes high power only while ACTIVE, the sink strap at any state.
// R11 - Excess demand engages limiting and sets the over-current flag.
// R12 - Override disables protection and doubles the flag threshold.
// R13 - Low-power mode: trickle on, suspended when needed to stay in 100mA.
// R14 - High-power mode: fast charge allowed, throttled to stay in 500mA.
// R15 - No charging from USB unless in the sink role.
// R16 - Disconnect bit 14 opens the USB switch and leaves wall or battery as the source.
// R17 - Disconnect bit clears on reset, undervoltage lockout or boot failure.
// R18 - Source-role bit clears on reset and on source-to-sink transition.
// R19 - Sink high-power bit reset value comes from the configuration mode.
// R20 - Over-current flag latched on rising edge, bit 10 at 1Ah, read clears.
// R21 - Mask bit 10 at 22h blocks the flag from the interrupt; resets to 0.
// R22 - Current monitored in both roles with that role's high-power bit.
// R23 - Host should suspend USB when unused and pick power after enumeration.
// R24 - Interrupt output is the flag AND the inverted mask bit.
`timescale 1ns/1ps
`default_nettype none
`include "ssup_regs.svh"

module ssup_ctrl (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // Register port
  input wire logic [`SSUP_ADDR_W-1:0] reg_addr,
  input wire logic [`SSUP_DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [`SSUP_DATA_W-1:0] reg_rdata,
  // Comparator indications (asynchronous)
  input wire logic wall_in_window,
  input wire logic wall_highest,
  input wire logic usb_present,
  input wire logic usb_highest,
  input wire logic usb_above_4v0,
  input wire logic cell_input_present,
  input wire logic usb_demand_over_100ma,
  input wire logic usb_demand_over_500ma,
  input wire logic usb_demand_over_1a,
  input wire logic usb_demand_over_200ma,
  // Power manager status (same clock)
  input wire logic [1:0] pwr_state,
  input wire logic config_sink_high_power,
  input wire logic line_uvlo,
  input wire logic boot_hyst_fail,
  input wire logic off_to_active_req,
  // Source selection and role outputs
  output logic [1:0] src_sel,
  output logic usb_switch_closed,
  output logic usb_source_role,
  output logic usb_high_power,
  output logic usb_limit_active,
  output logic off_to_active_ok,
  // Charger gating
  output logic trickle_en,
  output logic fast_en,
  output logic fast_throttle,
  // Interrupt
  output logic usb_irq
);

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  // Comparators settle on their own time; two flops keep metastability out
  localparam int NSYNC = 10;
  logic [NSYNC-1:0] async_in;
  logic [NSYNC-1:0] sync1_r;
  logic [NSYNC-1:0] sync2_r;
  assign async_in = {usb_demand_over_200ma, usb_demand_over_1a,
                     usb_demand_over_500ma, usb_demand_over_100ma,
                     cell_input_present, usb_above_4v0, usb_highest,
                     usb_present, wall_highest, wall_in_window};

  genvar gi;
  generate
    for (gi = 0; gi < NSYNC; gi++) begin : g_sync
      always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
          sync1_r[gi] <= 1'b0;
          sync2_r[gi] <= 1'b0;
        end else begin
          sync1_r[gi] <= async_in[gi];
          sync2_r[gi] <= sync1_r[gi];
        end
      end
    end
  endgenerate

  logic s_wall_ok;
  logic s_wall_hi;
  logic s_usb_pres;
  logic s_usb_hi;
  logic s_usb_4v0;
  logic s_cell;
  logic s_ovr100;
  logic s_ovr500;
  logic s_ovr1a;
  logic s_ovr200;
  assign s_wall_ok = sync2_r[0];
  assign s_wall_hi = sync2_r[1];
  assign s_usb_pres = sync2_r[2];
  assign s_usb_hi = sync2_r[3];
  assign s_usb_4v0 = sync2_r[4];
  assign s_cell = sync2_r[5];
  assign s_ovr100 = sync2_r[6];
  assign s_ovr500 = sync2_r[7];
  assign s_ovr1a = sync2_r[8];
  assign s_ovr200 = sync2_r[9];

  // ----------------------------------------------------------------
  // Register access decode
  // ----------------------------------------------------------------
  function automatic logic hit(input logic [`SSUP_ADDR_W-1:0] a,
                               input logic [`SSUP_ADDR_W-1:0] ofs);
    hit = (a == ofs);
  endfunction

  logic wr_ctrl2;
  logic wr_mask2;
  logic wr_chg;
  logic rd_stat2;
  assign wr_ctrl2 = reg_wr && hit(reg_addr, `SSUP_OFS_SYS_CTRL2);
  assign wr_mask2 = reg_wr && hit(reg_addr, `SSUP_OFS_INT_MASK2);
  assign wr_chg = reg_wr && hit(reg_addr, `SSUP_OFS_CHG_CTRL);
  assign rd_stat2 = reg_rd && hit(reg_addr, `SSUP_OFS_INT_STAT2);

  logic is_active;
  assign is_active = (pwr_state == ssup_pkg::SSUP_PWR_ACTIVE);

  // ----------------------------------------------------------------
  // System control two
  // ----------------------------------------------------------------
  logic disconnect_r;
  logic src_role_r;
  logic src_hipwr_r;
  logic sink_hipwr_r;
  logic limit_ovr_r;
  logic fast_req_r;
  logic usb_over_rail;
  logic role_drop;
  // USB rising above the rail means the far side now feeds this device,
  // so the role state falls back to sink and the source bit clears
  assign usb_over_rail = s_usb_pres && s_usb_hi;
  assign role_drop = src_role_r && usb_over_rail; // [R18]

  // Lockout and boot failure reopen USB so the next start may use it
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      disconnect_r <= 1'b0; // [R17]
    end else if (line_uvlo || boot_hyst_fail) begin
      disconnect_r <= 1'b0; // [R17]
    end else if (wr_ctrl2) begin
      disconnect_r <= reg_wdata[`SSUP_BIT_DISCONNECT]; // [R16]
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      src_role_r <= 1'b0; // [R07] [R18]
    end else if (role_drop) begin
      src_role_r <= 1'b0; // [R18]
    end else if (wr_ctrl2) begin
      src_role_r <= reg_wdata[`SSUP_BIT_SRC_ROLE]; // [R07]
    end
  end

  // High power may only be picked while ACTIVE; a write elsewhere clears it
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      src_hipwr_r <= 1'b0; // [R10]
    end else if (wr_ctrl2) begin
      src_hipwr_r <= reg_wdata[`SSUP_BIT_SRC_HIPWR] & is_active; // [R10]
    end
  end

  // Strap is caught by a clocked process right after reset release
  logic strap_done_r;
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      strap_done_r <= 1'b0;
    end else begin
      strap_done_r <= 1'b1;
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      sink_hipwr_r <= 1'b0;
    end else if (!strap_done_r) begin
      sink_hipwr_r <= config_sink_high_power; // [R19]
    end else if (line_uvlo || boot_hyst_fail) begin
      sink_hipwr_r <= 1'b0;
    end else if (wr_ctrl2) begin
      sink_hipwr_r <= reg_wdata[`SSUP_BIT_SINK_HIPWR] & is_active; // [R10]
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      limit_ovr_r <= 1'b0;
    end else if (wr_ctrl2) begin
      limit_ovr_r <= reg_wdata[`SSUP_BIT_LIMIT_OVR]; // [R12]
    end
  end

  // Software fast-charge request; honoured only where allowed
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      fast_req_r <= 1'b0;
    end else if (wr_chg) begin
      fast_req_r <= reg_wdata[`SSUP_BIT_FAST_REQ];
    end
  end

  // ----------------------------------------------------------------
  // Source selection
  // ----------------------------------------------------------------
  logic usb_usable;
  logic [1:0] src_nxt;
  assign usb_usable = s_usb_pres && !disconnect_r && !src_role_r;

  always_comb begin
    if (s_wall_ok || s_wall_hi) begin
      src_nxt = ssup_pkg::SSUP_SRC_WALL; // [R01] [R02] [R03]
    end else if (usb_usable && s_usb_hi) begin
      src_nxt = ssup_pkg::SSUP_SRC_USB; // [R04] [R08] [R16]
    end else begin
      src_nxt = ssup_pkg::SSUP_SRC_CELL_INPUT; // [R05] [R16]
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      src_sel <= ssup_pkg::SSUP_SRC_CELL_INPUT;
    end else begin
      src_sel <= src_nxt;
    end
  end

  assign usb_switch_closed = !disconnect_r; // [R16]
  assign usb_source_role = src_role_r; // [R07]

  // ----------------------------------------------------------------
  // Current limit and over-current event
  // ----------------------------------------------------------------
  logic role_hipwr;
  logic over_now;
  logic over_prev_r;
  logic flag_r;
  logic mask_r;
  assign role_hipwr = src_role_r ? src_hipwr_r : sink_hipwr_r; // [R22]
  assign usb_high_power = role_hipwr; // [R10]

  // Override doubles the event threshold: 200mA or 1A instead of 100/500mA
  always_comb begin
    if (limit_ovr_r) begin
      over_now = role_hipwr ? s_ovr1a : s_ovr200; // [R12]
    end else begin
      over_now = role_hipwr ? s_ovr500 : s_ovr100; // [R11] [R22]
    end
  end

  // Protection off while overridden; steady load above 500mA is unsafe
  assign usb_limit_active = over_now && !limit_ovr_r; // [R11] [R12]

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      over_prev_r <= 1'b0;
    end else begin
      over_prev_r <= over_now;
    end
  end

  // Set beats the read clear so an edge in the read cycle is kept
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      flag_r <= 1'b0;
    end else if (over_now && !over_prev_r) begin
      flag_r <= 1'b1; // [R20]
    end else if (rd_stat2) begin
      flag_r <= 1'b0; // [R20]
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      mask_r <= 1'b0; // [R21]
    end else if (wr_mask2) begin
      mask_r <= reg_wdata[`SSUP_BIT_OVERCURRENT];
    end
  end

  assign usb_irq = flag_r && !mask_r; // [R21] [R24]

  // ----------------------------------------------------------------
  // Charger gating and start-up permission
  // ----------------------------------------------------------------
  logic on_wall;
  logic on_usb_sink;
  assign on_wall = (src_sel == ssup_pkg::SSUP_SRC_WALL);
  assign on_usb_sink = (src_sel == ssup_pkg::SSUP_SRC_USB) && !src_role_r;

  always_comb begin
    trickle_en = 1'b0;
    fast_en = 1'b0;
    fast_throttle = 1'b0;
    if (s_cell && on_wall) begin
      trickle_en = (pwr_state != ssup_pkg::SSUP_PWR_OTHER); // [R06]
      fast_en = fast_req_r && is_active; // [R06]
    end else if (s_cell && on_usb_sink) begin // [R15]
      if (role_hipwr) begin
        trickle_en = 1'b1;
        fast_en = fast_req_r && is_active; // [R14]
        fast_throttle = s_ovr500; // [R14]
      end else begin
        trickle_en = !s_ovr100; // [R13]
      end
    end
  end

  // Start from USB needs the 4.0V comparator; wall or battery always ok
  assign off_to_active_ok = off_to_active_req &&
    ((src_sel != ssup_pkg::SSUP_SRC_USB) || s_usb_4v0); // [R09]

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  // Zero outside the answer cycle so stale data never linger on the bus
  logic [`SSUP_DATA_W-1:0] rd_nxt;
  always_comb begin
    rd_nxt = `SSUP_ZERO16;
    if (reg_rd) begin
      case (reg_addr)
        `SSUP_OFS_SYS_CTRL2: begin
          rd_nxt[`SSUP_BIT_DISCONNECT] = disconnect_r;
          rd_nxt[`SSUP_BIT_SRC_ROLE] = src_role_r;
          rd_nxt[`SSUP_BIT_SRC_HIPWR] = src_hipwr_r;
          rd_nxt[`SSUP_BIT_SINK_HIPWR] = sink_hipwr_r;
          rd_nxt[`SSUP_BIT_LIMIT_OVR] = limit_ovr_r;
        end
        `SSUP_OFS_INT_STAT2: rd_nxt[`SSUP_BIT_OVERCURRENT] = flag_r;
        `SSUP_OFS_INT_MASK2: rd_nxt[`SSUP_BIT_OVERCURRENT] = mask_r;
        `SSUP_OFS_CHG_CTRL: rd_nxt[`SSUP_BIT_FAST_REQ] = fast_req_r;
        `SSUP_OFS_SRC_STAT: rd_nxt = {11'h000, usb_limit_active,
                                      trickle_en, fast_en, src_sel};
        default: rd_nxt = `SSUP_ZERO16;
      endcase
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      reg_rdata <= `SSUP_ZERO16;
    end else begin
      reg_rdata <= rd_nxt;
    end
  end

endmodule // ssup_ctrl
`default_nettype wire

// >>> verilog/ssup_regs.svh
// Register offsets, field positions and write mask of the supply control
`ifndef SSUP_REGS_SVH
`define SSUP_REGS_SVH

`define SSUP_ADDR_W 8
`define SSUP_DATA_W 16
`define SSUP_OFS_SYS_CTRL2 8'h04
`define SSUP_OFS_INT_STAT2 8'h1a
`define SSUP_OFS_INT_MASK2 8'h22
`define SSUP_OFS_CHG_CTRL 8'h40
`define SSUP_OFS_SRC_STAT 8'h41

`define SSUP_BIT_DISCONNECT 14
`define SSUP_BIT_SRC_ROLE 13
`define SSUP_BIT_SRC_HIPWR 11
`define SSUP_BIT_SINK_HIPWR 9
`define SSUP_BIT_LIMIT_OVR 8
`define SSUP_BIT_OVERCURRENT 10
`define SSUP_BIT_FAST_REQ 0

`define SSUP_SYS_CTRL2_WMASK 16'h6b00
`define SSUP_ZERO16 16'h0000

`endif

// >>> verilog/ssup_pkg.sv
// Types shared by the supply control logic
`default_nettype none
package ssup_pkg;
  typedef enum logic [1:0] {
    SSUP_SRC_CELL_INPUT,
    SSUP_SRC_WALL,
    SSUP_SRC_USB
  } ssup_src_e;

  typedef enum logic [1:0] {
    SSUP_PWR_OFF,
    SSUP_PWR_HIBERNATE,
    SSUP_PWR_ACTIVE,
    SSUP_PWR_OTHER
  } ssup_pwr_e;
endpackage
`default_nettype wire

// >>> sim/ssup_supply_model.sv
// Model of the wall adaptor, USB supply and cell behind the comparators
`timescale 1ns/1ps
`default_nettype none
module ssup_supply_model (
  // Scenario controls
  input wire logic [1:0] wall_lvl,
  input wire logic usb_on,
  input wire logic usb_low,
  input wire logic [2:0] load,
  // Comparator levels
  output logic wall_in_window,
  output logic wall_highest,
  output logic usb_present,
  output logic usb_highest,
  output logic usb_above_4v0,
  output logic cell_input_present,
  output logic [3:0] over
);
  // Wall level 1 is below 4.0V, 2 in window and highest, 3 under USB
  assign wall_in_window = wall_lvl[1];
  assign wall_highest = (wall_lvl != 2'h0) && !(usb_on && wall_lvl != 2'h2);
  assign usb_present = usb_on;
  assign usb_highest = usb_on && !wall_highest;
  // A low USB supply stays present but sits under the 4.0V comparator
  assign usb_above_4v0 = usb_on && !usb_low;
  assign cell_input_present = 1'b1;
  // Demand steps: over 100mA, 200mA, 500mA, 1A
  assign over = {load >= 3'h4, load >= 3'h3, load >= 3'h2, load >= 3'h1};
endmodule // ssup_supply_model
`default_nettype wire

// >>> sim/ssup_ctrl_sva.sv
// Concurrent checks on the supply control ports
`timescale 1ns/1ps
`default_nettype none
module ssup_ctrl_sva (
  // Clock, reset and register port
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic [7:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_rdata,
  // Comparators and power manager
  input wire logic wall_in_window,
  input wire logic usb_above_4v0,
  input wire logic [1:0] pwr_state,
  input wire logic line_uvlo,
  input wire logic boot_hyst_fail,
  input wire logic off_to_active_req,
  // Outputs
  input wire logic [1:0] src_sel,
  input wire logic usb_switch_closed,
  input wire logic usb_source_role,
  input wire logic usb_high_power,
  input wire logic off_to_active_ok,
  input wire logic fast_en
);
  localparam logic [1:0] USB = ssup_pkg::SSUP_SRC_USB;
  localparam logic [1:0] WALL = ssup_pkg::SSUP_SRC_WALL;
  localparam logic [1:0] ACT = ssup_pkg::SSUP_PWR_ACTIVE;
  logic wr04;
  logic clr;
  assign wr04 = reg_wr && reg_addr == 8'h04;
  assign clr = line_uvlo || boot_hyst_fail;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  a_rdata_idle: assert property (
    !$past(reg_rd) |-> reg_rdata == 16'h0000)
    else $error("read data outside its answer cycle");
  // Five samples cover the three-edge comparator latency
  a_wall_not_usb: assert property (
    wall_in_window [*5] |-> src_sel != USB)
    else $error("USB chosen beside a suitable wall supply");
  a_disc_no_usb: assert property (
    !usb_switch_closed [*4] |-> src_sel != USB)
    else $error("USB chosen while disconnected");
  a_ok_gate: assert property (
    off_to_active_ok |-> off_to_active_req &&
    (src_sel != USB || $past(usb_above_4v0, 2)))
    else $error("start-up allowed on a low USB supply");
  a_fast_wall: assert property (
    fast_en && src_sel == WALL |-> pwr_state == ACT)
    else $error("fast charge outside active state");
  a_hp_refused: assert property (
    wr04 && pwr_state != ACT |=> !usb_high_power)
    else $error("high power taken outside active state");
  a_hp_taken: assert property (
    wr04 && pwr_state == ACT && !reg_wdata[13] && !clr |=>
    usb_high_power == $past(reg_wdata[9]) && !usb_source_role)
    else $error("sink high power not taken");
  a_disc_write: assert property (wr04 && !clr |=>
    usb_switch_closed == !$past(reg_wdata[14]))
    else $error("disconnect bit not taken");
  a_clr_disc: assert property (clr |=> usb_switch_closed)
    else $error("disconnect survives lockout");
endmodule // ssup_ctrl_sva
`default_nettype wire

// >>> sim/ssup_ctrl_tb_top.sv
// Self-checking bench for the supply control block
`timescale 1ns/1ps
`default_nettype none
module ssup_ctrl_tb_top;
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [15:0] reg_wdata = 16'h0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [1:0] pwr_state = 2'h0;
  logic line_uvlo = 1'b0;
  logic req = 1'b0;
  logic [1:0] wall_lvl = 2'h0;
  logic usb_on = 1'b0;
  logic [2:0] load = 3'h0;
  logic usb_low = 1'b0;
  logic boot_fail = 1'b0;
  logic cfg_hp = 1'b1;
  logic [15:0] reg_rdata;
  logic wall_in_window, wall_highest, usb_present, usb_highest;
  logic usb_above_4v0, cell_input_present;
  logic [3:0] over;
  logic [1:0] src_sel;
  logic usb_switch_closed, usb_source_role, usb_high_power;
  logic usb_limit_active, off_to_active_ok, trickle_en, fast_en;
  logic fast_throttle, usb_irq;
  int failures = 0;
  int tests_run = 0;
  always #4 clk_sys = ~clk_sys;
  ssup_supply_model u_sup (.wall_lvl, .usb_on, .usb_low, .load,
    .wall_in_window, .wall_highest, .usb_present, .usb_highest,
    .usb_above_4v0,
    .cell_input_present, .over);
  ssup_ctrl u_dut (.clk_sys, .sys_rst, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata, .wall_in_window, .wall_highest, .usb_present,
    .usb_highest, .usb_above_4v0, .cell_input_present,
    .usb_demand_over_100ma(over[0]), .usb_demand_over_200ma(over[1]),
    .usb_demand_over_500ma(over[2]), .usb_demand_over_1a(over[3]),
    .pwr_state, .config_sink_high_power(cfg_hp), .line_uvlo,
    .boot_hyst_fail(boot_fail), .off_to_active_req(req), .src_sel,
    .usb_switch_closed, .usb_source_role, .usb_high_power, .usb_limit_active,
    .off_to_active_ok, .trickle_en, .fast_en, .fast_throttle, .usb_irq);
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, e);
  endtask
  // Fixed wait covers the three-edge comparator latency
  task automatic supply(input logic [1:0] l, input logic u,
                        input logic [2:0] d);
    @(posedge clk_sys);
    wall_lvl <= l;
    usb_on <= u;
    load <= d;
    repeat (5) @(posedge clk_sys);
    #1;
  endtask
  task automatic t_reset;
    rd(8'h04, 16'h0200);
    rd(8'h1a, 16'h0000);
    rd(8'h22, 16'h0000);
    rd(8'h7f, 16'h0000);
    wr(8'h04, 16'h4200);
    rd(8'h04, 16'h4000);
    wr(8'h04, 16'h0000);
  endtask
  task automatic t_select;
    logic [4:0] c [6] = '{5'b10_1_01, 5'b11_1_01, 5'b01_0_01,
      5'b01_1_10, 5'b00_1_10, 5'b00_0_00};
    logic [15:0] e;
    for (int i = 0; i < 6; i++) begin
      supply(c[i][4:3], c[i][2], 3'h0);
      e = {14'h0, c[i][1:0]};
      chk({14'h0, src_sel}, e);
    end
  endtask
  task automatic t_disc;
    supply(2'h0, 1'b1, 3'h0);
    wr(8'h04, 16'h4000);
    supply(2'h0, 1'b1, 3'h0);
    chk({14'h0, src_sel}, 16'h0000);
    @(posedge clk_sys);
    line_uvlo <= 1'b1;
    @(posedge clk_sys);
    line_uvlo <= 1'b0;
    supply(2'h0, 1'b1, 3'h0);
    chk({14'h0, src_sel}, 16'h0002);
    @(posedge clk_sys);
    req <= 1'b1;
    @(posedge clk_sys);
    #1 chk({15'h0, off_to_active_ok}, 16'h0001);
    @(posedge clk_sys);
    usb_low <= 1'b1;
    repeat (3) @(posedge clk_sys);
    #1 chk({15'h0, off_to_active_ok}, 16'h0000);
    @(posedge clk_sys);
    usb_low <= 1'b0;
    req <= 1'b0;
  endtask
  task automatic t_limit;
    @(posedge clk_sys);
    pwr_state <= 2'h2;
    wr(8'h04, 16'h0000);
    supply(2'h0, 1'b1, 3'h1);
    chk({13'h0, usb_limit_active, usb_irq, trickle_en},
      16'h0006);
    rd(8'h1a, 16'h0400);
    rd(8'h1a, 16'h0000);
    chk({15'h0, usb_irq}, 16'h0000);
    wr(8'h22, 16'h0400);
    supply(2'h0, 1'b1, 3'h0);
    chk({15'h0, trickle_en}, 16'h0001);
    supply(2'h0, 1'b1, 3'h1);
    chk({15'h0, usb_irq}, 16'h0000);
    rd(8'h1a, 16'h0400);
    wr(8'h22, 16'h0000);
    wr(8'h04, 16'h0300);
    supply(2'h0, 1'b1, 3'h3);
    chk({13'h0, usb_limit_active, usb_irq, fast_throttle},
      16'h0001);
    supply(2'h0, 1'b1, 3'h4);
    chk({15'h0, usb_irq}, 16'h0001);
    rd(8'h1a, 16'h0400);
  endtask
  task automatic t_fast;
    supply(2'h2, 1'b0, 3'h0);
    wr(8'h40, 16'h0001);
    #1 chk({15'h0, fast_en}, 16'h0001);
    @(posedge clk_sys);
    pwr_state <= 2'h0;
    @(posedge clk_sys);
    #1 chk({14'h0, fast_en, trickle_en}, 16'h0001);
    wr(8'h04, 16'h2000);
    #1 chk({15'h0, usb_source_role}, 16'h0001);
    supply(2'h0, 1'b1, 3'h0);
    chk({15'h0, usb_source_role}, 16'h0000);
  endtask
  // Mid-run reset with the strap low, then a boot failure
  task automatic t_rst2;
    supply(2'h2, 1'b0, 3'h0);
    wr(8'h04, 16'h2000);
    @(posedge clk_sys);
    cfg_hp <= 1'b0;
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    sys_rst <= 1'b0;
    repeat (2) @(posedge clk_sys);
    #1 chk({13'h0, src_sel, usb_source_role}, 16'h0000);
    rd(8'h04, 16'h0000);
    wr(8'h04, 16'h4000);
    rd(8'h04, 16'h4000);
    @(posedge clk_sys);
    boot_fail <= 1'b1;
    @(posedge clk_sys);
    boot_fail <= 1'b0;
    rd(8'h04, 16'h0000);
  endtask
  task automatic summarize;
    $display("Checks %0d, mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge clk_sys);
    sys_rst <= 1'b0;
    repeat (2) @(posedge clk_sys);
    t_reset();
    t_select();
    t_disc();
    t_limit();
    t_fast();
    t_rst2();
    summarize();
  end
endmodule // ssup_ctrl_tb_top
bind ssup_ctrl ssup_ctrl_sva u_sva (.clk_sys, .sys_rst, .reg_addr, .reg_wdata,
  .reg_wr, .reg_rd, .reg_rdata, .wall_in_window, .usb_above_4v0, .pwr_state,
  .line_uvlo, .boot_hyst_fail, .off_to_active_req, .src_sel,
  .usb_switch_closed, .usb_source_role, .usb_high_power, .off_to_active_ok,
  .fast_en);
`default_nettype wire
